// ---- src/dbc_pkg.sv ----
package dbc_pkg;

  // Serial data word layout
  localparam int WORD_W = 16;
  localparam int TYPE_HI = 15;
  localparam int TYPE_LO = 13;
  localparam int USER_BIT = 12;
  localparam int CODE_W = 12;
  localparam logic [2:0] TYPE_SOFTWARE = 3'h4;
  localparam logic [2:0] TYPE_BOOST = 3'h3;

  // Command codes of the software command register
  localparam logic [11:0] CODE_RESET = 12'h555;
  localparam logic [11:0] CODE_SERVICE = 12'h195;

  // Boost control field positions
  localparam int COMP_POS = 6;
  localparam int PHASE_POS = 4;
  localparam int FREQ_POS = 2;
  localparam int VMAX_POS = 0;

  // Boost control values after reset
  localparam logic COMP_RST = 1'b0;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] FREQ_RST = 2'h1;
  localparam logic [1:0] VMAX_RST = 2'h0;

  // Phase modes
  localparam logic [1:0] PHASE_ALL_SAME = 2'h0;
  localparam logic [1:0] PHASE_AB_CD = 2'h1;
  localparam logic [1:0] PHASE_AC_BD = 2'h2;
  localparam logic [1:0] PHASE_QUAD = 2'h3;

  // Clock rate and switching frequencies
  localparam int CLK_HZ = 100_000_000;
  localparam int FREQ_SLOW_HZ = 250_000;
  localparam int FREQ_MID_HZ = 410_000;
  localparam int FREQ_FAST_HZ = 650_000;
  localparam int DIV_SLOW = CLK_HZ / FREQ_SLOW_HZ;
  localparam int DIV_MID = CLK_HZ / FREQ_MID_HZ;
  localparam int DIV_FAST = CLK_HZ / FREQ_FAST_HZ;
  localparam int DIV_W = 16;

  // Watchdog timeout
  localparam int WDOG_TIMEOUT_US = 5000;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_US * (CLK_HZ / 1_000_000);

  // Link bit counter
  localparam int BITCNT_W = 5;

endpackage

// ---- src/dbc_link_rx.sv ----
`timescale 1ns/1ps
// Link-side receiver: shifts one 16-bit word per frame on the link clock
module dbc_link_rx
  import dbc_pkg::*;
(
  input wire logic sclk_in,
  input wire logic rst_n_in,
  input wire logic sync_n_in,
  input wire logic sdin_in,
  output logic [WORD_W-1:0] word_out,
  output logic word_tgl_out
);

  logic [WORD_W-2:0] shift_r; // Bits received so far, MSB first
  logic [BITCNT_W-1:0] bit_cnt_r; // Bits in this frame

  // Bit count; the frame signal clears it since the link clock stops between frames
  always_ff @(posedge sclk_in or negedge rst_n_in or posedge sync_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_r <= '0;
    end else if (sync_n_in) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r != BITCNT_W'(WORD_W)) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  // Shift in data; extra bits past the word are ignored
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= '0;
    end else if (!sync_n_in && bit_cnt_r < BITCNT_W'(WORD_W - 1)) begin
      shift_r <= {shift_r[WORD_W-3:0], sdin_in};
    end
  end

  // Whole word held stable and announced by a toggle for the crossing
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_out <= '0;
      word_tgl_out <= 1'b0;
    end else if (!sync_n_in && bit_cnt_r == BITCNT_W'(WORD_W - 1)) begin
      word_out <= {shift_r, sdin_in};
      word_tgl_out <= ~word_tgl_out;
    end
  end

endmodule

// ---- src/dbc_regs.sv ----
`timescale 1ns/1ps
// Software command and boost control registers with watchdog and switching clocks
module dbc_regs
  import dbc_pkg::*;
#(
  parameter int WDOG_TIMEOUT_CYCLES = WDOG_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic sdin_in,
  input wire logic wdog_enable_in,
  output logic status_toggle_out,
  output logic soft_reset_out,
  output logic alert_out,
  output logic boost_comp_select_out,
  output logic [1:0] boost_phase_select_out,
  output logic [1:0] boost_freq_select_out,
  output logic [1:0] boost_vmax_select_out,
  output logic [3:0] boost_clk_out
);

  localparam int WD_W = $clog2(WDOG_TIMEOUT_CYCLES + 1);

  // Refuse a timeout too short for the counter to serve
  if (WDOG_TIMEOUT_CYCLES < 2) begin : g_bad_timeout
    $error("WDOG_TIMEOUT_CYCLES must be at least 2");
  end

  logic [WORD_W-1:0] link_word; // Held word from the link domain
  logic link_tgl; // Flips once per received word
  logic tgl_meta_r; // First synchroniser stage
  logic tgl_sync_r; // Second synchroniser stage
  logic tgl_seen_r; // Last toggle already handled
  logic new_word; // One-cycle pulse per word
  logic wr_sw; // Software command write
  logic wr_boost; // Boost control write
  logic [CODE_W-1:0] code; // Command code field
  logic do_reset; // Reset code received
  logic do_kick; // Service code received
  logic [WD_W-1:0] wd_cnt_r; // Cycles since last service
  logic [DIV_W-1:0] div_cnt_r; // Switching period counter
  logic [DIV_W-1:0] div_cur; // Period for the selected frequency
  logic [3:0] clk_nxt; // Next switching clock levels

  // Limitation: integer dividers only approximate the nominal switching rates
  // Frequency code to divider; code 11 falls back to the default period
  function automatic logic [DIV_W-1:0] div_of(input logic [1:0] sel);
    case (sel)
      2'h0: div_of = DIV_W'(DIV_SLOW);
      2'h1: div_of = DIV_W'(DIV_MID);
      2'h2: div_of = DIV_W'(DIV_FAST);
      default: div_of = DIV_W'(DIV_MID);
    endcase
  endfunction

  // Level of one channel clock shifted by an offset within the period
  function automatic logic ch_level(input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] off,
                                    input logic [DIV_W-1:0] div);
    logic [DIV_W:0] s;
    s = {1'b0, cnt} + {1'b0, off};
    if (s >= {1'b0, div}) begin
      s = s - {1'b0, div};
    end
    ch_level = s < {2'b00, div[DIV_W-1:1]};
  endfunction

  // The receiver shares the device reset, so a frame cut by reset starts clean
  // Receiver on the link clock
  dbc_link_rx u_rx (
    .sclk_in(sclk_in),
    .rst_n_in(rst_n_in),
    .sync_n_in(sync_n_in),
    .sdin_in(sdin_in),
    .word_out(link_word),
    .word_tgl_out(link_tgl)
  );

  // Only the toggle crosses; the word waits in the link domain, so no bit of it is caught mid-change
  // Toggle crossing; the word is read only after the toggle settles, so it is stable by then
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= link_tgl;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  // Words of any other type fall through without effect
  // Decode of the received word
  assign new_word = tgl_sync_r ^ tgl_seen_r;
  assign code = link_word[CODE_W-1:0];
  assign wr_sw = new_word && link_word[TYPE_HI:TYPE_LO] == TYPE_SOFTWARE;
  assign wr_boost = new_word && link_word[TYPE_HI:TYPE_LO] == TYPE_BOOST;
  assign do_reset = wr_sw && code == CODE_RESET;
  assign do_kick = wr_sw && code == CODE_SERVICE;

  // Reset pulse for the rest of the device
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= do_reset;
    end
  end

  // User toggle bit; a reset write clears it with everything else
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_toggle_out <= 1'b0;
    end else if (do_reset) begin
      status_toggle_out <= 1'b0;
    end else if (wr_sw) begin
      status_toggle_out <= link_word[USER_BIT];
    end
  end

  // Boost control fields; bits 12 to 7 are ignored
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boost_comp_select_out <= COMP_RST;
      boost_phase_select_out <= PHASE_RST;
      boost_freq_select_out <= FREQ_RST;
      boost_vmax_select_out <= VMAX_RST;
    end else if (do_reset) begin
      boost_comp_select_out <= COMP_RST;
      boost_phase_select_out <= PHASE_RST;
      boost_freq_select_out <= FREQ_RST;
      boost_vmax_select_out <= VMAX_RST;
    end else if (wr_boost) begin
      boost_comp_select_out <= link_word[COMP_POS];
      boost_phase_select_out <= link_word[PHASE_POS+1:PHASE_POS];
      boost_freq_select_out <= link_word[FREQ_POS+1:FREQ_POS];
      boost_vmax_select_out <= link_word[VMAX_POS+1:VMAX_POS];
    end
  end

  // Limitation: the enable is taken as a level of this clock domain, with no synchroniser
  // Watchdog counter; it restarts on service, on reset code and while disabled
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_cnt_r <= '0;
    end else if (!wdog_enable_in || do_kick || do_reset) begin
      wd_cnt_r <= '0;
    end else if (wd_cnt_r != WD_W'(WDOG_TIMEOUT_CYCLES)) begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // Service and timeout in one cycle: service wins, so a late service still rescues the count
  // Alert holds from timeout until serviced, reset code or disabled
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alert_out <= 1'b0;
    end else if (!wdog_enable_in || do_kick || do_reset) begin
      alert_out <= 1'b0;
    end else if (wd_cnt_r == WD_W'(WDOG_TIMEOUT_CYCLES - 1)) begin
      alert_out <= 1'b1;
    end
  end

  // Switching period counter; wraps early if a faster frequency shortens the period
  assign div_cur = div_of(boost_freq_select_out);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= '0;
    end else if (div_cnt_r >= div_cur - 1'b1) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // Channel clock offsets per phase mode; an inverted copy keeps edges exactly opposite even for an odd period
  always_comb begin
    logic [DIV_W-1:0] quarter;
    quarter = {2'b00, div_cur[DIV_W-1:2]};
    clk_nxt[0] = ch_level(div_cnt_r, '0, div_cur);
    case (boost_phase_select_out)
      PHASE_ALL_SAME: begin
        clk_nxt[3:1] = {3{clk_nxt[0]}};
      end
      PHASE_AB_CD: begin
        clk_nxt[1] = clk_nxt[0];
        clk_nxt[2] = ~clk_nxt[0];
        clk_nxt[3] = ~clk_nxt[0];
      end
      PHASE_AC_BD: begin
        clk_nxt[2] = clk_nxt[0];
        clk_nxt[1] = ~clk_nxt[0];
        clk_nxt[3] = ~clk_nxt[0];
      end
      PHASE_QUAD: begin
        // B leads A by a quarter period; C and D are the inverses of A and B
        clk_nxt[1] = ch_level(div_cnt_r, quarter, div_cur);
        clk_nxt[2] = ~clk_nxt[0];
        clk_nxt[3] = ~clk_nxt[1];
      end
      default: begin
        clk_nxt[3:1] = {3{clk_nxt[0]}};
      end
    endcase
  end

  // Registering costs a cycle of lag but keeps decode glitches off the switching clocks
  // Registered switching clocks, channel A in bit 0
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boost_clk_out <= '0;
    end else begin
      boost_clk_out <= clk_nxt;
    end
  end

  // All checks run on the system clock and rest while reset is held
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Software writes copy the user bit unless the word is the reset code
  a_toggle_copy: assert property (wr_sw && code != CODE_RESET |=> status_toggle_out == $past(link_word[USER_BIT]))
    else $error("toggle bit not copied");
  // A reset code gives a pulse of exactly one cycle
  a_reset_pulse: assert property (do_reset |=> soft_reset_out ##1 (!soft_reset_out || $past(do_reset)))
    else $error("reset pulse wrong");
  // The pulse and the restored defaults appear together
  a_reset_defaults: assert property (soft_reset_out |-> !boost_comp_select_out && boost_phase_select_out == PHASE_RST
    && boost_freq_select_out == FREQ_RST && boost_vmax_select_out == VMAX_RST && !status_toggle_out)
    else $error("reset left fields set");
  // The pulse never comes without a reset code the cycle before
  a_reset_cause: assert property (soft_reset_out |-> $past(do_reset))
    else $error("reset pulse without reset code");
  // A reset code clears the user bit even though it carries a one
  a_toggle_reset: assert property (do_reset |=> !status_toggle_out)
    else $error("toggle bit kept over reset");

  // Boost writes land in all four fields at once
  a_boost_store: assert property (wr_boost |=> {boost_comp_select_out, boost_phase_select_out, boost_freq_select_out,
    boost_vmax_select_out} == $past(link_word[6:0]))
    else $error("boost fields not stored");
  // Fields hold between boost writes and reset codes
  a_boost_hold: assert property (!wr_boost && !do_reset |=> $stable(boost_comp_select_out)
    && $stable(boost_freq_select_out) && $stable(boost_vmax_select_out) && $stable(boost_phase_select_out))
    else $error("boost field changed without write");
  // A software write other than reset leaves the comp and freq fields alone
  a_sw_no_boost: assert property (wr_sw && !do_reset |=> $stable(boost_comp_select_out)
    && $stable(boost_freq_select_out))
    else $error("software write touched boost fields");
  // Nothing but a write moves vmax, phase or the toggle bit
  a_other_ignore: assert property (!wr_sw && !wr_boost |=> $stable(boost_vmax_select_out)
    && $stable(boost_phase_select_out) && $stable(status_toggle_out))
    else $error("register changed without write");
  // The crossing gives one decode pulse per received word
  a_word_pulse: assert property (new_word |=> !new_word)
    else $error("word decoded twice");

  // Service restarts the count and clears the alert
  a_wdog_kick: assert property (do_kick |=> wd_cnt_r == 0 && !alert_out)
    else $error("service did not restart watchdog");
  // Alert rises on the cycle the count runs out
  a_alert_set: assert property (wdog_enable_in && !wr_sw && wd_cnt_r == WD_W'(WDOG_TIMEOUT_CYCLES - 1)
    |=> alert_out)
    else $error("alert missing after timeout");
  // Alert never rises before the count runs out
  a_alert_early: assert property (alert_out |-> $past(wd_cnt_r) >= WD_W'(WDOG_TIMEOUT_CYCLES - 1))
    else $error("alert before timeout");
  // While raised, the alert sits with the count saturated at the timeout
  a_alert_count: assert property (alert_out |-> wd_cnt_r == WD_W'(WDOG_TIMEOUT_CYCLES))
    else $error("alert without full count");
  // Alert holds until service, reset code or disable
  a_alert_hold: assert property (alert_out && wdog_enable_in && !do_kick && !do_reset |=> alert_out)
    else $error("alert dropped while unserviced");
  // A disabled watchdog neither counts nor alerts
  a_alert_off: assert property (!wdog_enable_in |=> !alert_out && wd_cnt_r == 0)
    else $error("watchdog active while disabled");

  // Mode 00: all channels share one level
  a_phase_same: assert property ($past(boost_phase_select_out) == PHASE_ALL_SAME
    |-> boost_clk_out == 4'h0 || boost_clk_out == 4'hf)
    else $error("channels not on same edge");
  // Mode 01: A with B, C and D on the opposite edge
  a_phase_abcd: assert property ($past(boost_phase_select_out) == PHASE_AB_CD
    |-> boost_clk_out[0] == boost_clk_out[1] && boost_clk_out[2] == boost_clk_out[3]
    && boost_clk_out[2] != boost_clk_out[0])
    else $error("channel pairs split");
  // Mode 10: A with C, B and D on the opposite edge
  a_phase_acbd: assert property ($past(boost_phase_select_out) == PHASE_AC_BD
    |-> boost_clk_out[0] == boost_clk_out[2] && boost_clk_out[1] == boost_clk_out[3]
    && boost_clk_out[1] != boost_clk_out[0])
    else $error("channel pairs a c split");
  // Mode 11: C and D sit half a period from A and B
  a_phase_quad: assert property ($past(boost_phase_select_out) == PHASE_QUAD
    |-> boost_clk_out[2] != boost_clk_out[0] && boost_clk_out[3] != boost_clk_out[1])
    else $error("quad channels not opposed");

endmodule

// ---- verification/dbc_host_model.sv ----
`timescale 1ns/1ps
// Host model: writes words MSB first, link clock runs only inside frames
module dbc_host_model (
  output logic sclk_out,
  output logic sync_n_out,
  output logic sdin_out
);
  // Idle: clock low and still, frame deselected
  initial begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    sdin_out = 1'b0;
  end

  // Shift nbits of w from D15 down; a short count leaves the frame incomplete
  task automatic send_word(input logic [15:0] w, input int nbits);
    #13;
    sync_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdin_out = w[15-i];
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
    #32 sync_n_out = 1'b1;
    // Released line must not hold the last bit
    sdin_out = ~sdin_out;
  endtask
endmodule

// ---- verification/dbc_regs_tb_top.sv ----
`timescale 1ns/1ps
// Bench for the software command and boost control registers
module dbc_regs_tb_top;
  import dbc_pkg::*;
  localparam int WD = 20; // Short watchdog keeps the run brief
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wdog_enable_in = 1'b0;
  logic sclk, sync_n, sdin, tgl, srst, alert, comp;
  logic [1:0] phase, freq, vmax;
  logic [3:0] bclk;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int per;
  logic [6:0] e;
  int divs [3] = '{DIV_SLOW, DIV_MID, DIV_FAST};

  always #5 mclk_in = ~mclk_in;

  dbc_host_model host (.sclk_out(sclk), .sync_n_out(sync_n), .sdin_out(sdin));

  dbc_regs #(.WDOG_TIMEOUT_CYCLES(WD)) DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sync_n_in(sync_n), .sdin_in(sdin),
    .wdog_enable_in(wdog_enable_in), .status_toggle_out(tgl), .soft_reset_out(srst),
    .alert_out(alert), .boost_comp_select_out(comp), .boost_phase_select_out(phase),
    .boost_freq_select_out(freq), .boost_vmax_select_out(vmax), .boost_clk_out(bclk)
  );

  // Compare small values exactly, an unknown bit matches only an unknown bit
  task automatic chk_val(input logic [3:0] got, input logic [3:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compare a measured switching period in cycles
  task automatic chk_per(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH t=%0t period got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Full frame, then room for the crossing and decode
  task automatic wr(input logic [15:0] w);
    host.send_word(w, 16);
    repeat (8) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk_boost(input logic [6:0] x);
    chk_val({3'h0, comp}, {3'h0, x[6]}, "comp");
    chk_val({2'h0, phase}, {2'h0, x[5:4]}, "phase");
    chk_val({2'h0, freq}, {2'h0, x[3:2]}, "freq");
    chk_val({2'h0, vmax}, {2'h0, x[1:0]}, "vmax");
  endtask

  // Channel A period between its second and third rise, so a change in mid-period is skipped
  task automatic meas_per(output int p);
    logic prev;
    int n;
    int r;
    int t;
    prev = 1'b1;
    n = 0;
    r = 0;
    t = 0;
    p = 0;
    while (n < 3000 && r < 3) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (bclk[0] === 1'b1 && prev === 1'b0) begin
        r++;
        if (r == 3) p = n - t;
        t = n;
      end
      prev = bclk[0];
    end
  endtask

  // Channels against A in each of the four phase modes; in quad mode D is checked against B
  task automatic chk_phase(input logic [1:0] ph);
    logic a;
    repeat (60) begin
      @(posedge mclk_in);
      #1;
      a = bclk[0];
      case (ph)
        2'h0: chk_val(bclk, {4{a}}, "same edge");
        2'h1: chk_val(bclk, {~a, ~a, a, a}, "ab cd");
        2'h2: chk_val(bclk, {~a, a, ~a, a}, "ac bd");
        default: chk_val(bclk, {~bclk[1], ~a, bclk[1], a}, "quad");
      endcase
    end
  endtask

  // Cycles from a channel B rise to the next channel A rise
  task automatic meas_lead(output int p);
    logic pa;
    logic pb;
    int n;
    bit go;
    pa = 1'b1;
    pb = 1'b1;
    n = 0;
    go = 1'b0;
    p = 0;
    while (p == 0 && n < 1000) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (go && bclk[0] === 1'b1 && pa === 1'b0) p = n;
      if (!go && bclk[1] === 1'b1 && pb === 1'b0) begin
        go = 1'b1;
        n = 0;
      end
      pa = bclk[0];
      pb = bclk[1];
    end
  endtask

  // Hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk_val({3'h0, tgl}, 4'h0, "toggle");
    chk_boost(7'h04);
    wr({TYPE_SOFTWARE, 1'b1, 12'h000});
    chk_val({3'h0, tgl}, 4'h1, "toggle set");
    wr({TYPE_SOFTWARE, 1'b0, 12'hfff});
    chk_val({3'h0, tgl}, 4'h0, "toggle clear");
    // Foreign types and a short frame leave everything alone
    wr({3'h0, 1'b1, 12'h07f});
    wr({3'h7, 1'b1, 12'h07f});
    host.send_word({TYPE_SOFTWARE, 1'b1, 12'h000}, 15);
    repeat (8) @(posedge mclk_in);
    #1;
    chk_val({3'h0, tgl}, 4'h0, "ignored word");
    chk_boost(7'h04);
    // Every phase and voltage code and freq codes 00 to 10 with the free bits set; code 11 of freq never sent
    for (int k = 0; k < 4; k++) begin
      e = {k[0], k[1:0], (k == 3) ? 2'h2 : k[1:0], 2'(3 - k)};
      wr({TYPE_BOOST, 6'h3f, e});
      chk_boost(e);
      chk_phase(k[1:0]);
      meas_per(per);
      chk_per(per, divs[e[3:2]]);
    end
    // Quad mode at the fast rate: B leads A by a quarter period
    meas_lead(per);
    chk_per(per, divs[2] / 4);
    // Watchdog runs out exactly at the timeout, then a service word clears the alert
    wdog_enable_in = 1'b1;
    repeat (WD - 1) @(posedge mclk_in);
    #1;
    chk_val({3'h0, alert}, 4'h0, "early alert");
    @(posedge mclk_in);
    #1;
    chk_val({3'h0, alert}, 4'h1, "alert");
    wr({TYPE_SOFTWARE, 1'b1, CODE_SERVICE});
    chk_val({3'h0, alert}, 4'h0, "serviced");
    chk_val({3'h0, tgl}, 4'h1, "toggle on service");
    @(posedge mclk_in);
    #1 wdog_enable_in = 1'b0;
    // Reset code pulses once and restores the defaults; the pulse is watched while the frame runs
    wr({TYPE_BOOST, 6'h00, 7'h5a});
    chk_boost(7'h5a);
    per = 0;
    fork
      host.send_word({TYPE_SOFTWARE, 1'b1, CODE_RESET}, 16);
      begin
        while (srst !== 1'b1 && per < 200) begin
          @(posedge mclk_in);
          #1;
          per++;
        end
        chk_val({3'h0, srst}, 4'h1, "reset pulse");
        @(posedge mclk_in);
        #1;
        chk_val({3'h0, srst}, 4'h0, "pulse end");
      end
    join
    repeat (2) @(posedge mclk_in);
    #1;
    chk_boost(7'h04);
    chk_val({3'h0, tgl}, 4'h0, "toggle after reset");
    report_and_stop();
  end
endmodule
